/* hw/pem_consts.svh */
// Register offsets, field positions and reset values of the event mask block.
// Assumes inclusion by bare name from the design files.
`ifndef PEM_CONSTS_SVH
`define PEM_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PEM_OFS_SUMMARY   8'h00
`define PEM_OFS_MASK      8'h01
`define PEM_OFS_GLOB      8'h02
`define PEM_OFS_GLOB_COR  8'h03
`define PEM_OFS_CMD       8'h0B

// ****************************************
// Reset values
// ****************************************
`define PEM_MASK_RST      8'h80
`define PEM_GLOB_RST      8'h20

// ****************************************
// Field positions
// ****************************************
`define PEM_CMD_RELEASE   6
`define PEM_MB_PWR_EN     0
`define PEM_MB_PWR_GOOD   1
`define PEM_MB_DET        2
`define PEM_MB_CLASS      3
`define PEM_MB_DISC       4
`define PEM_MB_START      5
`define PEM_MB_IFAULT     6
`define PEM_MB_GLOBAL     7
`define PEM_GLOB_LSB      3

`endif

/* hw/pem_pkg.sv */
// Types shared by the event mask block.
// Assumes the constants header is compiled alongside.
package pem_pkg;

  // ****************************************
  // Block state
  // ****************************************
  typedef struct packed {
    logic [7:0]      mask;
    logic [3:0][6:0] port_ev;
    logic [7:0]      glob;
    logic            int_on;
    logic [7:0]      rdata;
  } pem_state_type;

endpackage

/* hw/pem_gate.sv */
// Per-class gate of new events onto the interrupt request.
// Assumes one new-event flag per class, indexed as the mask bits.
`timescale 1ns/1ps
module pem_gate #(
  parameter int N_CLASS = 8
) (
  input  wire logic [N_CLASS-1:0] class_hit,
  input  wire logic [N_CLASS-1:0] mask,
  output logic                    fire
);

  logic [N_CLASS-1:0] passed;

  // ****************************************
  // Gating per class
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < N_CLASS; i++) begin : g_cls
      assign passed[i] = class_hit[i] & mask[i];
    end
  endgenerate

  assign fire = |passed;

endmodule

/* hw/pem_top.sv */
// Interrupt mask, event recording, summary and interrupt pin of a
// four-port power controller.
// Assumes a register port decoded from the serial interface, synchronous
// event pulses per port and global fault levels.
//
// Notes on behaviour
// - A mask bit at one lets its event class assert the interrupt pin.
// - A mask bit at zero blocks its class from the pin; events still recorded.
// - Writing one to command bit six deasserts the interrupt pin unless an unmasked event arrives in the same cycle.
// - Mask bit five gates start-fault events of every port.
// - Mask bit two gates detection-done events of all four ports.
// - Summary register shows per port a one while any event is pending.
// - Reading the clear-on-read global copy clears both copies; faults re-set.
`timescale 1ns/1ps
`include "pem_consts.svh"
module pem_top #(
  parameter int N_PORT = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [N_PORT-1:0] ev_pwr_en,
  input  wire logic [N_PORT-1:0] ev_pwr_good,
  input  wire logic [N_PORT-1:0] ev_det_done,
  input  wire logic [N_PORT-1:0] ev_class_done,
  input  wire logic [N_PORT-1:0] ev_disconnect,
  input  wire logic [N_PORT-1:0] ev_start_fault,
  input  wire logic [N_PORT-1:0] ev_ifault,
  input  wire logic [N_PORT-1:0] port_ev_clear,
  input  wire logic              overtemp,
  input  wire logic              fet_fail,
  input  wire logic              logic_rail_lockout,
  input  wire logic              main_rail_lockout,
  input  wire logic              thermal_shutdown,
  output logic                   int_n,
  output logic      [7:0]        event_interrupt_mask
);

  pem_pkg::pem_state_type st;
  pem_pkg::pem_state_type next_st;

  logic [3:0][6:0] port_in;
  logic [7:0]      class_hit;
  logic [4:0]      glob_in;
  logic [3:0]      summary;
  logic            fire;
  logic            wr_mask;
  logic            release_int;
  logic            rd_cor;

  // ****************************************
  // Event inputs per port and class
  // ****************************************
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      assign port_in[p] = {ev_ifault[p], ev_start_fault[p],
                           ev_disconnect[p], ev_class_done[p],
                           ev_det_done[p], ev_pwr_good[p], ev_pwr_en[p]};
      assign summary[p] = |st.port_ev[p];
    end
  endgenerate

  assign glob_in = {overtemp, fet_fail, logic_rail_lockout,
                    main_rail_lockout, thermal_shutdown};

  // ****************************************
  // Class hits
  // ****************************************
  // class collection
  assign class_hit[`PEM_MB_PWR_EN]   = |ev_pwr_en;
  assign class_hit[`PEM_MB_PWR_GOOD] = |ev_pwr_good;
  assign class_hit[`PEM_MB_DET]      = |ev_det_done;
  assign class_hit[`PEM_MB_CLASS]    = |ev_class_done;
  assign class_hit[`PEM_MB_DISC]     = |ev_disconnect;
  assign class_hit[`PEM_MB_START]    = |ev_start_fault;
  assign class_hit[`PEM_MB_IFAULT]   = |ev_ifault;
  assign class_hit[`PEM_MB_GLOBAL]   = |(glob_in[4:1] & ~st.glob[7:4]);

  pem_gate #(
    .N_CLASS (8)
  ) u_gate (
    .class_hit (class_hit),
    .mask      (st.mask),
    .fire      (fire)
  );

  assign wr_mask     = reg_wr && (reg_addr == `PEM_OFS_MASK);
  assign release_int = reg_wr && (reg_addr == `PEM_OFS_CMD)
                       && reg_wdata[`PEM_CMD_RELEASE];
  assign rd_cor      = reg_rd && (reg_addr == `PEM_OFS_GLOB_COR);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    if (wr_mask) begin
      next_st.mask = reg_wdata;
    end
    for (int i = 0; i < 4; i++) begin
      if (port_ev_clear[i]) begin
        next_st.port_ev[i] = 7'h00;
      end
      next_st.port_ev[i] = next_st.port_ev[i] | port_in[i];
    end
    if (rd_cor) begin
      next_st.glob = 8'h00;
    end else begin
      next_st.glob[7:`PEM_GLOB_LSB] = st.glob[7:`PEM_GLOB_LSB] | glob_in;
    end
    if (release_int) begin
      next_st.int_on = 1'b0;
    end
    if (fire) begin
      next_st.int_on = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `PEM_OFS_SUMMARY: begin
          next_st.rdata = {st.glob[7:4], summary};
        end
        `PEM_OFS_MASK: begin
          next_st.rdata = st.mask;
        end
        `PEM_OFS_GLOB, `PEM_OFS_GLOB_COR: begin
          next_st.rdata = st.glob;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st.mask    <= `PEM_MASK_RST;
      st.port_ev <= '0;
      st.glob    <= `PEM_GLOB_RST;
      st.int_on  <= 1'b0;
      st.rdata   <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata            = st.rdata;
  assign int_n                = ~st.int_on;
  assign event_interrupt_mask = st.mask;

  // ****************************************
  // Assertions
  // ****************************************
  AST_MASK_PASS:
    assert property (@(posedge clk_sys) disable iff (reset)
      (|(class_hit & st.mask)) |=> !int_n)
    else $error("Unmasked event did not assert interrupt");

  AST_MASK_BLOCK:
    assert property (@(posedge clk_sys) disable iff (reset)
      (int_n && !fire && !st.mask[`PEM_MB_START] && ev_start_fault[1])
      |=> (int_n && st.port_ev[1][`PEM_MB_START]))
    else $error("Masked start fault not blocked or not recorded");

  AST_RELEASE:
    assert property (@(posedge clk_sys) disable iff (reset)
      (release_int && !fire) |=> int_n)
    else $error("Release write did not deassert interrupt");

  AST_START_GATE:
    assert property (@(posedge clk_sys) disable iff (reset)
      (st.mask[`PEM_MB_START] && (|ev_start_fault)) |=> !int_n)
    else $error("Start fault did not reach interrupt");

  AST_DET_GATE:
    assert property (@(posedge clk_sys) disable iff (reset)
      (int_n && class_hit == 8'h04
       && !st.mask[`PEM_MB_DET]) |=> int_n)
    else $error("Masked detection event asserted interrupt");

  AST_IFAULT_GATE:
    assert property (@(posedge clk_sys) disable iff (reset)
      (st.mask[`PEM_MB_IFAULT] && |ev_ifault) ##1 !release_int
      |=> !int_n)
    else $error("Current fault did not hold interrupt");

  AST_GLOBAL_GATE:
    assert property (@(posedge clk_sys) disable iff (reset)
      (st.mask[`PEM_MB_GLOBAL] && overtemp && !st.glob[7]) |=> !int_n)
    else $error("Global event did not reach interrupt");

  AST_SUMMARY:
    assert property (@(posedge clk_sys) disable iff (reset)
      (reg_rd && reg_addr == `PEM_OFS_SUMMARY && (|st.port_ev[2]))
      |=> reg_rdata[2])
    else $error("Summary flag missing for pending port");

  AST_COR_CLEAR:
    assert property (@(posedge clk_sys) disable iff (reset)
      rd_cor |=> (st.glob == 8'h00))
    else $error("Clear-on-read did not clear global events");

endmodule

/* tb/pem_host.sv */
// Host model driving the register port of the event mask block.
// Assumes strobes are sampled on the rising clk_sys edge.
`timescale 1ns/1ps
module pem_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  // ****
  // Idle state
  // ****
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* tb/poe_event_interrupt_mask_tb.sv */
// Self-checking bench of the event mask block.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
`include "pem_consts.svh"
module poe_event_interrupt_mask_tb;
  logic            clk_sys = 1'b0;
  logic            reset   = 1'b1;
  logic [6:0][3:0] evp     = '0;
  logic [3:0]      clr     = 4'h0;
  logic            ot      = 1'b0;
  logic            ff      = 1'b0;
  logic            lr      = 1'b0;
  logic            mr      = 1'b0;
  logic            tsd     = 1'b0;
  logic [7:0]      a;
  logic [7:0]      d;
  logic [7:0]      r;
  logic            wr;
  logic            rd;
  logic [7:0]      rdata;
  logic            int_n;
  logic [7:0]      msk;
  int              n_errors = 0;
  int              n_tests  = 0;

  always #12.5 clk_sys = ~clk_sys;

  pem_host u_host (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_addr(a),
    .reg_wr(wr), .reg_wdata(d), .reg_rd(rd));

  pem_top u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(a),
    .reg_wr(wr), .reg_wdata(d), .reg_rd(rd), .reg_rdata(rdata),
    .ev_pwr_en(evp[0]), .ev_pwr_good(evp[1]), .ev_det_done(evp[2]),
    .ev_class_done(evp[3]), .ev_disconnect(evp[4]),
    .ev_start_fault(evp[5]), .ev_ifault(evp[6]), .port_ev_clear(clr),
    .overtemp(ot), .fet_fail(ff), .logic_rail_lockout(lr),
    .main_rail_lockout(mr), .thermal_shutdown(tsd), .int_n(int_n),
    .event_interrupt_mask(msk));

  // ****
  // Helpers
  // ****
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic pulse(input int c, input int p);
    @(posedge clk_sys);
    evp[c][p] <= 1'b1;
    @(posedge clk_sys);
    evp[c][p] <= 1'b0;
    #1;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    u_host.rd(`PEM_OFS_MASK, r);
    check(r, `PEM_MASK_RST);
    u_host.rd(`PEM_OFS_GLOB, r);
    check(r, `PEM_GLOB_RST);
    check({7'h00, int_n}, 8'h01);
    $display("reset test done");
    for (int c = 0; c < 7; c++) begin
      u_host.wr(`PEM_OFS_MASK, 8'h01 << c);
      check(msk, 8'h01 << c);
      pulse(c, c % 4);
      check({7'h00, int_n}, 8'h00);
      u_host.wr(`PEM_OFS_CMD, 8'h40);
      check({7'h00, int_n}, 8'h01);
      u_host.wr(`PEM_OFS_MASK, ~(8'h01 << c));
      pulse(c, c % 4);
      check({7'h00, int_n}, 8'h01);
      u_host.rd(`PEM_OFS_SUMMARY, r);
      check(r, 8'h20 | (8'h01 << (c % 4)));
      @(posedge clk_sys);
      clr <= 4'hF;
      @(posedge clk_sys);
      clr <= 4'h0;
      u_host.rd(`PEM_OFS_SUMMARY, r);
      check(r, 8'h20);
    end
    $display("class gate test done");
    u_host.wr(`PEM_OFS_MASK, 8'h80);
    @(posedge clk_sys);
    ot <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, int_n}, 8'h00);
    u_host.rd(`PEM_OFS_GLOB_COR, r);
    check(r, 8'hA0);
    u_host.rd(`PEM_OFS_GLOB, r);
    check(r, 8'h80);
    u_host.rd(`PEM_OFS_SUMMARY, r);
    check(r, 8'h80);
    u_host.rd(`PEM_OFS_CMD, r);
    check(r, 8'h00);
    u_host.wr(`PEM_OFS_CMD, 8'h40);
    check({7'h00, int_n}, 8'h01);
    u_host.wr(`PEM_OFS_MASK, 8'h7F);
    @(posedge clk_sys);
    ff <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, int_n}, 8'h01);
    u_host.rd(`PEM_OFS_GLOB, r);
    check(r, 8'hC0);
    u_host.wr(`PEM_OFS_MASK, 8'h80);
    @(posedge clk_sys);
    lr  <= 1'b1;
    mr  <= 1'b1;
    tsd <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h00, int_n}, 8'h00);
    u_host.rd(`PEM_OFS_GLOB, r);
    check(r, 8'hF8);
    $display("global test done");
    complete_run();
  end

  initial begin
    #(25 * 6000);
    n_errors++;
    complete_run();
  end
endmodule
